//--- verilog/sebc_regs.vh
// Constants for the serial EEPROM bus client front end
// Notes on behaviour
// - Data changes only while clock low
// - Transfers begin only from idle bus
// - Data fall with clock high: Start
// - Data rise with clock high: Stop
// - One clock pulse per data bit
// - Write keeps only last sixteen bytes
// - Overflow replaces oldest byte first
// - Receiver acknowledges every received byte; control bytes with a wrong code or sent during a write cycle are refused
// - Acknowledge held low through high phase
// - Release data after host withholds acknowledge
// - Protect low: whole array writable
// - Protect high: writes blocked, reads normal
// - Unused select pins have no effect
// - Host owns clock; device only client
// - Host picks transmitter and receiver roles
// - Internal write cycle ends within bound
// - Output change delayed after clock fall
// - Control byte type code must match
// - Last control bit: one read, zero write
// - Stop after write data starts cycle
// - No acknowledge during write cycle
`ifndef SEBC_REGS_VH
`define SEBC_REGS_VH
`define SEBC_CTRL_CODE      4'hA
`define SEBC_CLK_NS         40
`define SEBC_TWC_MS         5
`define SEBC_TWC_CYC        ((`SEBC_TWC_MS * 1000000) / `SEBC_CLK_NS)
`define SEBC_HOLD_NS        300
`define SEBC_HOLD_CYC       ((`SEBC_HOLD_NS + `SEBC_CLK_NS - 1) / `SEBC_CLK_NS)
`define SEBC_PAGE_BYTES     16
`define SEBC_BIT_ACK        4'h8
`endif

//--- verilog/sebc_client.v
// Two-wire serial EEPROM client front end: framing, acknowledge, write cycle
`timescale 1ns/1ps
`include "sebc_regs.vh"
module sebc_client #(
  parameter TWC_CYC  = `SEBC_TWC_CYC,   // Internal write cycle length in clocks
  parameter HOLD_CYC = `SEBC_HOLD_CYC   // Output hold after clock fall
) (
  input  wire       CLK_I,              // System clock, 25 MHz
  input  wire       RST_N_I,            // Asynchronous reset, active low
  input  wire       CE_I,               // Clock enable, freezes all state
  input  wire       SCL_I,              // Serial clock pin
  input  wire       SDA_I,              // Serial data pin level
  output wire       SDA_O,              // Serial data drive value (always 0)
  output wire       SDA_OE_O,           // Serial data pull-low enable
  input  wire       WP_I,               // Write-protect pin
  input  wire       UNUSED_SELECT_PIN_0_I, // Unused select input
  input  wire       UNUSED_SELECT_PIN_1_I, // Unused select input
  input  wire       UNUSED_SELECT_PIN_2_I, // Unused select input
  output wire       START_O,            // Start seen, one-cycle pulse
  output wire       STOP_O,             // Stop seen, one-cycle pulse
  output wire       RX_VALID_O,         // Received byte available
  input  wire       RX_READY_I,         // Consumer takes received byte
  output wire [7:0] RX_DATA_O,          // Received byte
  output wire       RX_FIRST_O,         // Byte is the control byte
  input  wire       TX_VALID_I,         // Read data offered by core
  output wire       TX_READY_O,         // Read data slot free
  input  wire [7:0] TX_DATA_I,          // Read data from core
  output reg        RD_MODE_O,          // Current transfer is a read
  output reg        ADDR_OK_O,          // Control byte matched and acknowledged
  output reg  [2:0] BLOCK_SEL_O,        // Block select bits of control byte
  output reg        HOST_NAK_O,         // Host withheld acknowledge, pulse
  output reg        WR_CYCLE_O,         // Internal write cycle running
  output reg  [4:0] WR_COUNT_O          // Address byte plus page write bytes counted, max 17
);

  // State encodings, one-hot
  localparam ST_IDLE = 4'h1;            // Bus idle, waiting for Start
  localparam ST_RX   = 4'h2;            // Receiving bits
  localparam ST_TX   = 4'h4;            // Sending read data
  localparam ST_WAIT = 4'h8;            // Not addressed, ignore until Start
  // Refused control bytes and finished reads also park in wait

  // Pin synchronisers, two flops each
  // Preset high so the idle bus gives no false edge after reset
  // Edge detectors read only the second flop
  reg  [1:0] scl_s_r;                   // Clock synchroniser
  reg  [1:0] sda_s_r;                   // Data synchroniser
  reg        scl_d_r;                   // Previous synchronised clock
  reg        sda_d_r;                   // Previous synchronised data
  reg        wp_s0_r;                   // Write-protect first flop
  reg        wp_s1_r;                   // Write-protect second flop

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      wp_s0_r <= 1'b1;
      wp_s1_r <= 1'b1;
    end else if (CE_I) begin
      scl_s_r <= {scl_s_r[0], SCL_I};
      sda_s_r <= {sda_s_r[0], SDA_I};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      wp_s0_r <= WP_I;
      wp_s1_r <= wp_s0_r;
    end
  end

  wire scl   = scl_s_r[1];              // Clean clock level
  wire sda   = sda_s_r[1];              // Clean data level
  // Edge flags last one enabled cycle
  wire scl_r = scl & ~scl_d_r;          // Clock rising edge
  wire scl_f = ~scl & scl_d_r;          // Clock falling edge
  // Data edges while clock high stand for Start and Stop
  wire start_ev = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_ev  = scl & scl_d_r & ~sda_d_r & sda;
  // Select pins only feed an unused wire and affect nothing
  wire unused_sel = UNUSED_SELECT_PIN_0_I ^ UNUSED_SELECT_PIN_1_I ^
                    UNUSED_SELECT_PIN_2_I;

  // Framing registers
  reg  [3:0] state_r;                   // Framing state
  reg  [3:0] bit_cnt_r;                 // Clock pulse within byte
  reg  [7:0] shift_r;                   // Receive shift register
  reg  [7:0] tx_sh_r;                   // Transmit shift register
  reg        first_r;                   // Next byte is control byte
  reg        ack_req_r;                 // Drive acknowledge in ninth slot
  reg        drv_nxt;                   // Wanted pull-low level
  reg        drv_r;                     // Applied pull-low level
  reg  [3:0] hold_r;                    // Delay after clock fall
  reg        wr_data_r;                 // Last write data byte since Start came with write-protect low
  reg [31:0] twc_r;                     // Write cycle timer
  reg        st_p_r;                    // Start pulse
  reg        sp_p_r;                    // Stop pulse

  // Two-entry receive buffer
  reg  [7:0] rb_dat_r [0:1];            // Buffered bytes
  reg        rb_fst_r [0:1];            // Control byte marks
  reg        rb_wp_r;                   // Write pointer
  reg        rb_rp_r;                   // Read pointer
  reg  [1:0] rb_cnt_r;                  // Occupancy
  wire       rb_full  = rb_cnt_r[1];
  wire       rb_empty = (rb_cnt_r == 2'h0);
  wire       rb_pop   = ~rb_empty & RX_READY_I;
  reg        rb_push;                   // Byte completes this cycle
  reg        tx_have_r;                 // Holding a byte for read

  assign RX_VALID_O = ~rb_empty;
  assign RX_DATA_O  = rb_dat_r[rb_rp_r];
  assign RX_FIRST_O = rb_fst_r[rb_rp_r];
  assign TX_READY_O = ~tx_have_r;
  assign START_O    = st_p_r;
  assign STOP_O     = sp_p_r;
  assign SDA_O      = 1'b0;             // Open drain only pulls low
  assign SDA_OE_O   = drv_r;

  // Control byte decode
  function ctrl_match;
    input [7:0] b;
    begin
      ctrl_match = (b[7:4] == `SEBC_CTRL_CODE);
    end
  endfunction

  // Completed byte with current sample
  wire [7:0] rx_byte = {shift_r[6:0], sda};

  // Byte framing and acknowledge control
  // Pulse count runs 1..8 for data, 9 during a receive acknowledge slot
  // A fall at count 9 closes a receive slot and rearms the counter; on read the ninth rise rearms it
  // The first fall after Start sees count 0 and does nothing
  // Control byte decides ack, read or write, and block bits
  // Data bytes always acknowledged; overflow of the buffer drops
  // Start and Stop win over any bit activity in the same cycle
  // Read bytes are loaded from TX_DATA_I only at slot close
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      tx_sh_r     <= 8'hFF;
      first_r     <= 1'b0;
      ack_req_r   <= 1'b0;
      drv_nxt     <= 1'b0;
      wr_data_r   <= 1'b0;
      RD_MODE_O   <= 1'b0;
      ADDR_OK_O   <= 1'b0;
      BLOCK_SEL_O <= 3'h0;
      HOST_NAK_O  <= 1'b0;
      WR_COUNT_O  <= 5'h00;
      st_p_r      <= 1'b0;
      sp_p_r      <= 1'b0;
      rb_push     <= 1'b0;
      tx_have_r   <= 1'b0;
    end else if (CE_I) begin
      st_p_r     <= start_ev;
      sp_p_r     <= stop_ev;
      HOST_NAK_O <= 1'b0;
      rb_push    <= 1'b0;
      // Take read data whenever slot free
      if (TX_VALID_I && !tx_have_r) begin
        tx_have_r <= 1'b1;
      end
      if (start_ev) begin
        // Start aborts any partial byte
        state_r   <= ST_RX;
        bit_cnt_r <= 4'h0;
        first_r   <= 1'b1;
        ack_req_r <= 1'b0;
        drv_nxt   <= 1'b0;
        ADDR_OK_O <= 1'b0;
        RD_MODE_O <= 1'b0;
        wr_data_r <= 1'b0;
        WR_COUNT_O <= 5'h00;
      end else if (stop_ev) begin
        // Stop returns to idle
        state_r   <= ST_IDLE;
        bit_cnt_r <= 4'h0;
        ack_req_r <= 1'b0;
        drv_nxt   <= 1'b0;
        ADDR_OK_O <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            drv_nxt <= 1'b0;
          end
          ST_RX: begin
            if (scl_r && bit_cnt_r < `SEBC_BIT_ACK) begin
              shift_r <= rx_byte;
              if (bit_cnt_r == 4'h7) begin
                rb_push <= ~rb_full;
                if (first_r) begin
                  // Acknowledge only matching code, not during write cycle
                  ack_req_r   <= ctrl_match(rx_byte) & ~WR_CYCLE_O;
                  BLOCK_SEL_O <= rx_byte[3:1];
                  RD_MODE_O   <= rx_byte[0];
                end else begin
                  ack_req_r <= 1'b1;
                  if (!RD_MODE_O && WR_COUNT_O != 5'h00) begin
                    // Byte after address is write data; count caps at page
                    wr_data_r <= ~wp_s1_r;
                    if (WR_COUNT_O != `SEBC_PAGE_BYTES + 1) begin
                      WR_COUNT_O <= WR_COUNT_O + 5'h01;
                    end
                  end else if (!RD_MODE_O) begin
                    WR_COUNT_O <= 5'h01; // Address byte seen
                  end
                end
              end
            end
            // Pulses counted up to nine; the ninth holds until its fall
            if (scl_r) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_f) begin
              if (bit_cnt_r == `SEBC_BIT_ACK) begin
                // Acknowledge slot opens at the fall after bit eight
                drv_nxt <= ack_req_r;
              end else if (bit_cnt_r == `SEBC_BIT_ACK + 4'h1) begin
                // Acknowledge slot closes, counter rearmed
                bit_cnt_r <= 4'h0;
                drv_nxt <= 1'b0;
                if (first_r) begin
                  first_r <= 1'b0;
                  ADDR_OK_O <= ack_req_r;
                  if (!ack_req_r) begin
                    state_r <= ST_WAIT;
                  end else if (RD_MODE_O) begin
                    state_r <= ST_TX;
                    tx_sh_r <= tx_have_r ? TX_DATA_I : 8'hFF;
                    tx_have_r <= 1'b0;
                    drv_nxt <= tx_have_r ? ~TX_DATA_I[7] : 1'b0;
                  end
                end
              end
            end
          end
          ST_TX: begin
            if (scl_r) begin
              bit_cnt_r <= (bit_cnt_r == `SEBC_BIT_ACK) ? 4'h0 : bit_cnt_r + 4'h1;
              // Ninth rise with the line high: host withheld acknowledge
              if (bit_cnt_r == `SEBC_BIT_ACK && sda) begin
                HOST_NAK_O <= 1'b1;
                state_r    <= ST_WAIT;
              end
            end
            if (scl_f) begin
              if (bit_cnt_r == 4'h8) begin
                drv_nxt <= 1'b0;        // Release for host acknowledge
              end else if (bit_cnt_r == 4'h0) begin
                tx_sh_r   <= tx_have_r ? TX_DATA_I : 8'hFF;
                tx_have_r <= 1'b0;
                drv_nxt   <= tx_have_r ? ~TX_DATA_I[7] : 1'b0;
              end else begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                drv_nxt <= ~tx_sh_r[6];
              end
            end
          end
          ST_WAIT: begin
            drv_nxt <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Delayed application of output changes after clock fall
  // Synchronised fall is already two cycles late; hold adds more
  // Keeps our data edge clear of the host's clock fall
  // While the clock is high only Start or Stop changes it, by releasing the line
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      drv_r  <= 1'b0;
      hold_r <= 4'h0;
    end else if (CE_I) begin
      if (scl_f) begin
        hold_r <= HOLD_CYC[3:0];
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end else if (!scl) begin
        drv_r <= drv_nxt;
      end else if (start_ev || stop_ev) begin
        drv_r <= 1'b0;
      end
    end
  end

  // Receive buffer, stalls keep stored words steady
  // Two slots; a byte arriving at a full buffer is dropped
  // Consumer sees data only while valid is high
  // Pointers wrap by toggling
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rb_wp_r     <= 1'b0;
      rb_rp_r     <= 1'b0;
      rb_cnt_r    <= 2'h0;
      rb_dat_r[0] <= 8'h00;
      rb_dat_r[1] <= 8'h00;
      rb_fst_r[0] <= 1'b0;
      rb_fst_r[1] <= 1'b0;
    end else if (CE_I) begin
      if (rb_push) begin
        rb_dat_r[rb_wp_r] <= shift_r;
        rb_fst_r[rb_wp_r] <= first_r;
        rb_wp_r <= ~rb_wp_r;
      end
      if (rb_pop) begin
        rb_rp_r <= ~rb_rp_r;
      end
      rb_cnt_r <= rb_cnt_r + {1'b0, rb_push} - {1'b0, rb_pop};
    end
  end

  // Internal write cycle timer
  // Armed by Stop only after acknowledged write data
  // Freezes with clock enable, so length counts enabled clocks
  // Control bytes are refused while it runs
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WR_CYCLE_O <= 1'b0;
      twc_r      <= 32'h0;
    end else if (CE_I) begin
      if (WR_CYCLE_O) begin
        if (twc_r == 32'h0) begin
          WR_CYCLE_O <= 1'b0;
        end else begin
          twc_r <= twc_r - 32'h1;
        end
      end else if (stop_ev && wr_data_r && ADDR_OK_O && state_r == ST_RX) begin
        // Address matched and write data held
        WR_CYCLE_O <= 1'b1;
        twc_r      <= TWC_CYC - 1;
      end
    end
  end

endmodule

//--- test/sebc_client_asserts.sv
// Concurrent checks on the serial EEPROM client ports
`timescale 1ns/1ps
module sebc_client_asserts #(
  parameter TWC_CYC = 300  // Write cycle length in clocks
) (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire       CE_I,
  input wire       SCL_I,
  input wire       SDA_I,
  input wire       SDA_OE_O,
  input wire       START_O,
  input wire       STOP_O,
  input wire       RX_VALID_O,
  input wire       RX_READY_I,
  input wire [7:0] RX_DATA_O,
  input wire       HOST_NAK_O,
  input wire       WR_CYCLE_O,
  input wire [4:0] WR_COUNT_O
);
  reg [15:0] busy_cnt_r;  // Cycles of the running write cycle
  // Count write-cycle clocks, cleared when idle
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) busy_cnt_r <= 16'h0000;
    else if (!WR_CYCLE_O) busy_cnt_r <= 16'h0000;
    else if (CE_I) busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  default clocking dflt_cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_start_cause: assert property (START_O |-> $past(SCL_I, 2) && !$past(SDA_I, 2))
    else $error("start pulse without data fall under high clock");
  a_stop_cause: assert property (STOP_O |-> $past(SCL_I, 2) && $past(SDA_I, 2))
    else $error("stop pulse without data rise under high clock");
  a_busy_no_ack: assert property (WR_CYCLE_O |-> !SDA_OE_O)
    else $error("data line driven during write cycle");
  a_cycle_len: assert property ($fell(WR_CYCLE_O) |-> busy_cnt_r == TWC_CYC)
    else $error("write cycle length wrong");
  a_count_cap: assert property (WR_COUNT_O <= 5'h11)
    else $error("held byte count beyond limit");
  a_oe_hold: assert property ($fell(SCL_I) |=> $stable(SDA_OE_O)[*2])
    else $error("data drive changed too soon after clock fall");
  a_high_steady: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
    else $error("data drive changed while clock high");
  a_nak_release: assert property (HOST_NAK_O |-> !SDA_OE_O[*4])
    else $error("data line held after host withheld acknowledge");
  a_rx_hold: assert property (RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O))
    else $error("received byte lost while stalled");
  c_busy: cover property ($rose(WR_CYCLE_O));
  c_nak: cover property (HOST_NAK_O);
  c_start: cover property (START_O);
endmodule
bind sebc_client sebc_client_asserts #(.TWC_CYC(TWC_CYC)) chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_OE_O(SDA_OE_O), .START_O(START_O), .STOP_O(STOP_O), .RX_VALID_O(RX_VALID_O),
  .RX_READY_I(RX_READY_I), .RX_DATA_O(RX_DATA_O), .HOST_NAK_O(HOST_NAK_O),
  .WR_CYCLE_O(WR_CYCLE_O), .WR_COUNT_O(WR_COUNT_O));

//--- test/sebc_host_model.sv
// Behavioural two-wire host that clocks the bus for the client
`timescale 1ns/1ps
module sebc_host_model (
  input  wire clk_i,   // Bench clock, timing base
  input  wire sda_i,   // Resolved data line
  output reg  scl_o,   // Serial clock, idle high
  output reg  pull_o   // High while host pulls data low
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // Wait a number of bench clock falls
  task tk(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data falls with clock high, from an idle bus
  task start;
    pull_o = 1'b1;
    tk(4);
    scl_o = 1'b0;
  endtask
  // Data rises with clock high, then bus left idle
  task stop;
    tk(1);
    pull_o = 1'b1;
    tk(5);
    scl_o = 1'b1;
    tk(4);
    pull_o = 1'b0;
    tk(8);
  endtask
  // Nine pulses, first bit first; a one releases the line
  task xfer(input [8:0] o, output [8:0] i);
    integer k;
    for (k = 8; k >= 0; k = k - 1) begin
      tk(1);
      pull_o = ~o[k];
      tk(5);
      scl_o = 1'b1;
      tk(1);
      i[k] = sda_i;
      tk(1);
      scl_o = 1'b0;
    end
  endtask
endmodule

//--- test/serial_eeprom_bus_client_test.sv
// Self-checking bench for the serial EEPROM client front end
`timescale 1ns/1ps
module serial_eeprom_bus_client_test;
  localparam TWC = 300;         // Shortened write cycle
  reg        clk = 1'b0;        // Bench clock
  reg        rst_n = 1'b0;      // Reset, active low
  reg        wp = 1'b0;         // Write protect
  reg  [2:0] sel = 3'h0;        // Unused select pins
  reg        rx_ready = 1'b0;   // Consumer ready
  reg        tx_valid = 1'b0;   // Read byte offered
  reg  [7:0] tx_data = 8'h00;   // Read byte
  reg        stall = 1'b0;      // Consumer held off
  reg  [8:0] got;               // Bits seen by host
  reg  [2:0] blk;               // Block select used
  reg  [7:0] d;                 // Scratch byte
  reg  [8:0] exp_q[$];          // Control mark and byte expected out
  reg        fst = 1'b0;        // Next byte follows a Start
  reg        rdy_nxt;           // Ready chosen for the coming edge
  reg        ce = 1'b1;         // Clock enable
  integer    st_exp = 0;        // Starts made by the host
  integer    sp_exp = 0;        // Stops made by the host
  integer    st_got = 0;        // Start pulses seen
  integer    sp_got = 0;        // Stop pulses seen
  integer    n;
  integer    room;
  integer    err_total = 0;
  integer    checks_done = 0;
  wire       scl, pull, sda_oe, rx_valid, rx_first, tx_ready;
  wire       rd_mode, addr_ok, nak, wr_cyc, start_p, stop_p, sda_o;
  wire [7:0] rx_data;
  wire [2:0] blk_sel;
  wire [4:0] wr_cnt;
  wire       sda = ~(pull | sda_oe);  // Open drain with pull-up
  always #20 clk = ~clk;
  sebc_client #(.TWC_CYC(TWC), .HOLD_CYC(2)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WP_I(wp), .UNUSED_SELECT_PIN_0_I(sel[0]),
    .UNUSED_SELECT_PIN_1_I(sel[1]), .UNUSED_SELECT_PIN_2_I(sel[2]), .START_O(start_p),
    .STOP_O(stop_p), .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .RX_DATA_O(rx_data),
    .RX_FIRST_O(rx_first), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
    .TX_DATA_I(tx_data), .RD_MODE_O(rd_mode), .ADDR_OK_O(addr_ok), .BLOCK_SEL_O(blk_sel),
    .HOST_NAK_O(nak), .WR_CYCLE_O(wr_cyc), .WR_COUNT_O(wr_cnt));
  sebc_host_model host_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  // Compare and count
  task chk(input [15:0] e, input [15:0] g, input [63:0] nm);
    checks_done = checks_done + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  endtask
  // Send a byte; bytes kept by the client are queued first
  task wb(input [7:0] b, input nak_exp);
    reg keep;
    keep = !stall || room > 0;
    if (keep) exp_q.push_back({fst, b});
    fst = 1'b0;
    if (stall) room = room - 1;
    host_u.xfer({b, 1'b1}, got);
    chk(nak_exp, got[0], "ack");
  endtask
  // Hand one read byte to the client
  task offer(input [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  // Verdict
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Drain received bytes at random pace, in order
  always @(negedge clk) begin
    rdy_nxt = !stall && ($urandom % 2);
    if (rx_valid && rdy_nxt) begin
      chk(exp_q[0], {rx_first, rx_data}, "rxbyte");
      exp_q.pop_front();
    end
    rx_ready <= rdy_nxt;
  end
  // Count Start and Stop from the host's own pins
  always @(posedge pull) begin
    if (scl === 1'b1) begin
      fst = 1'b1;
      st_exp = st_exp + 1;
    end
  end
  always @(negedge pull) begin
    if (scl === 1'b1 && rst_n === 1'b1) sp_exp = sp_exp + 1;
  end
  // Count condition pulses reported by the client
  always @(negedge clk) begin
    if (start_p === 1'b1) st_got = st_got + 1;
    if (stop_p === 1'b1) sp_got = sp_got + 1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    conclude;
  end
  initial begin
    void'($urandom(16));
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    host_u.tk(8);
    blk = 3'($urandom);
    sel = 3'($urandom);
    host_u.start;
    wb({4'hA, blk, 1'b0}, 1'b0);
    host_u.tk(4);
    chk({blk, 2'b01}, {blk_sel, rd_mode, addr_ok}, "ctrl");
    for (n = 0; n < 18; n = n + 1) wb(8'($urandom), 1'b0);
    chk(5'h11, wr_cnt, "count");
    host_u.stop;
    chk(1'b1, wr_cyc, "busy");
    host_u.start;
    wb({4'hA, blk, 1'b0}, 1'b1);
    host_u.stop;
    ce = 1'b0;
    host_u.tk(10);
    ce = 1'b1;
    chk(1'b1, wr_cyc, "frozen");
    for (n = 0; n < TWC && wr_cyc !== 1'b0; n = n + 1) @(negedge clk);
    chk(1'b0, wr_cyc, "done");
    host_u.start;
    wb({4'hA, blk, 1'b0}, 1'b0);
    host_u.stop;
    host_u.start;
    wb({4'h5, blk, 1'b0}, 1'b1);
    host_u.stop;
    wp = 1'b1;
    sel = 3'($urandom);
    while (exp_q.size() != 0) @(negedge clk);
    stall = 1'b1;
    room = 2;
    host_u.start;
    wb({4'hA, blk, 1'b0}, 1'b0);
    for (n = 0; n < 2; n = n + 1) wb(8'($urandom), 1'b0);
    stall = 1'b0;
    host_u.stop;
    chk(1'b0, wr_cyc, "prot");
    for (n = 0; n < 3; n = n + 1) begin
      d = 8'($urandom);
      offer(d);
      host_u.start;
      wb({4'hA, blk, 1'b1}, 1'b0);
      chk(1'b1, rd_mode, "rdmode");
      host_u.xfer(9'h1FF, got);
      chk(d, got[8:1], "rdata");
      host_u.stop;
    end
    host_u.tk(200);
    chk(16'h0000, 16'(exp_q.size()), "left");
    chk(16'(st_exp), 16'(st_got), "starts");
    chk(16'(sp_exp), 16'(sp_got), "stops");
    chk(1'b0, sda_o, "sdao");
    conclude;
  end
endmodule
